//--- core/dmdp_defs.vh
// constants for the data manipulation datapath
`ifndef DMDP_DEFS_VH
`define DMDP_DEFS_VH

// ************************************************************
// word layout
// ************************************************************
`define DMDP_WORD_W      36
`define DMDP_DATA_W      32
`define DMDP_PAR_W       4
`define DMDP_PAR_HI      35
`define DMDP_PAR_LO      32
`define DMDP_DATA_HI     31
`define DMDP_SCR_W       16
`define DMDP_SCR_DEPTH   16
`define DMDP_SCR_ADR_W   4
`define DMDP_SLICE_W     4
`define DMDP_NSLICE      4
`define DMDP_ZERO_WORD   36'h0_0000_0000
`define DMDP_ZERO_SCRHI  20'h0_0000
`define DMDP_NO_ZERO     6'h20
`define DMDP_PAR_ODD     1'b1

// ************************************************************
// microinstruction fields
// ************************************************************
`define DMDP_MI_W        64
`define DMDP_F_SRC_HI    3
`define DMDP_F_SRC_LO    0
`define DMDP_F_DST_HI    7
`define DMDP_F_DST_LO    4
`define DMDP_F_ADR_HI    11
`define DMDP_F_ADR_LO    8
`define DMDP_F_OP_HI     15
`define DMDP_F_OP_LO     12
`define DMDP_F_MASK_HI   19
`define DMDP_F_MASK_LO   16
`define DMDP_F_GB_DRIVE  20
`define DMDP_F_GB_LOAD   21
`define DMDP_F_MATCH     22
`define DMDP_F_PARGEN    23
`define DMDP_F_ROT_HI    37
`define DMDP_F_ROT_LO    36

// ************************************************************
// source and destination selects
// ************************************************************
`define DMDP_SEL_EXT     4'h0
`define DMDP_SEL_TEMP    4'h1
`define DMDP_SEL_FIRM    4'h2
`define DMDP_SEL_GBUF    4'h3
`define DMDP_DST_NONE    4'h0
`define DMDP_SEL_W       4

// ************************************************************
// arithmetic stage operations
// ************************************************************
`define DMDP_OP_PASS     4'h0
`define DMDP_OP_ADD      4'h1
`define DMDP_OP_SUB      4'h2
`define DMDP_OP_AND      4'h3
`define DMDP_OP_OR       4'h4
`define DMDP_OP_XOR      4'h5
`define DMDP_OP_FLZ      4'h6

// ************************************************************
// rotate amounts
// ************************************************************
`define DMDP_ROT_0       2'h0
`define DMDP_ROT_8       2'h1
`define DMDP_ROT_16      2'h2
`define DMDP_ROT_24      2'h3

`endif

//--- core/dmdp_scratch.v
// sixteen 16-bit scratch registers built from 4-bit wide slices
`include "dmdp_defs.vh"

module dmdp_scratch (
	input  wire                          clk,
	input  wire                          rst,
	input  wire                          wr_en,
	input  wire [`DMDP_SCR_ADR_W-1:0]    wr_adr,
	input  wire [`DMDP_SCR_W-1:0]        wr_data,
	input  wire [`DMDP_SCR_ADR_W-1:0]    rd_adr,
	output wire [`DMDP_SCR_W-1:0]        rd_data
);

	genvar s;
	generate
		// each slice holds four bits of every register
		for (s = 0; s < `DMDP_NSLICE; s = s + 1) begin : g_slice
			reg [`DMDP_SLICE_W-1:0] mem_reg [0:`DMDP_SCR_DEPTH-1];
			integer i;
			always @(posedge clk) begin
				if (rst) begin
					for (i = 0; i < `DMDP_SCR_DEPTH; i = i + 1) begin
						mem_reg[i] <= 4'h0;
					end
				end else if (wr_en) begin
					mem_reg[wr_adr] <= wr_data[s*`DMDP_SLICE_W +: `DMDP_SLICE_W]; // [RL9]
				end
			end
			assign rd_data[s*`DMDP_SLICE_W +: `DMDP_SLICE_W] = mem_reg[rd_adr]; // [RL9]
		end
	endgenerate

endmodule // dmdp_scratch

//--- core/dmdp_top.v
// data manipulation datapath: rotate, mask, arithmetic, parity, scratch registers
// Functional notes
// RL1: rotate data right by 0, 8, 16, 24
// RL2: mask stage blanks unselected operand bytes
// RL3: add, subtract or logic op, result to destination
// RL4: report lowest zero bit position of source
// RL5: matcher flags error when inputs differ
// RL6: fresh parity generated for produced data
// RL7: parity bits bypass the arithmetic stage
// RL8: scratch registers keep only bits 15..0
// RL9: sixteen temporary registers from 4-bit slices
// RL10: destination decode loads, source decode drives
// RL11: gating buffer passes data both directions
// RL12: one odd parity bit per byte
// RL13: no zero found gives defined indication
`include "dmdp_defs.vh"

module dmdp_top (
	input  wire                        CLK_SYS,
	input  wire                        SYS_RST,
	input  wire                        MI_VALID,
	input  wire [`DMDP_MI_W-1:0]       MI_WORD,
	input  wire [`DMDP_WORD_W-1:0]     EXT_SRC_DATA,
	input  wire [`DMDP_WORD_W-1:0]     GB_IN,
	output reg  [`DMDP_WORD_W-1:0]     GB_OUT,
	output reg                         GB_OE,
	output reg  [`DMDP_WORD_W-1:0]     DST_BUS,
	output reg                         DST_VALID,
	output reg  [`DMDP_SEL_W-1:0]      DST_SEL,
	output reg                         MATCH_ERR
);

	// ************************************************************
	// microinstruction field decode
	// ************************************************************
	wire [3:0] src_sel  = MI_WORD[`DMDP_F_SRC_HI:`DMDP_F_SRC_LO];
	wire [3:0] dst_sel  = MI_WORD[`DMDP_F_DST_HI:`DMDP_F_DST_LO];
	wire [3:0] scr_adr  = MI_WORD[`DMDP_F_ADR_HI:`DMDP_F_ADR_LO];
	wire [3:0] alu_op   = MI_WORD[`DMDP_F_OP_HI:`DMDP_F_OP_LO];
	wire [3:0] byte_msk = MI_WORD[`DMDP_F_MASK_HI:`DMDP_F_MASK_LO];
	wire [1:0] rot_sel  = MI_WORD[`DMDP_F_ROT_HI:`DMDP_F_ROT_LO];
	wire       gb_drive = MI_WORD[`DMDP_F_GB_DRIVE];
	wire       gb_load  = MI_WORD[`DMDP_F_GB_LOAD];
	wire       match_en = MI_WORD[`DMDP_F_MATCH];
	wire       par_gen  = MI_WORD[`DMDP_F_PARGEN];

	// ************************************************************
	// command strobes
	// ************************************************************
	// every strobe is qualified by a valid microinstruction
	wire       temp_wr  = MI_VALID && (dst_sel == `DMDP_SEL_TEMP);
	wire       firm_wr  = MI_VALID && (dst_sel == `DMDP_SEL_FIRM);
	wire       gbuf_wr  = MI_VALID && (dst_sel == `DMDP_SEL_GBUF);
	wire       gbuf_ld  = MI_VALID && gb_load;
	wire       match_op = MI_VALID && match_en;

	// ************************************************************
	// scratch registers and gating buffer
	// ************************************************************
	reg  [`DMDP_WORD_W-1:0] gbuf_reg;
	reg  [`DMDP_WORD_W-1:0] gbuf_next;
	reg  [`DMDP_WORD_W-1:0] src_bus;
	reg  [`DMDP_WORD_W-1:0] result;
	wire [`DMDP_SCR_W-1:0]  temp_rd;
	wire [`DMDP_SCR_W-1:0]  firm_rd;
	wire                    ld = MI_VALID && (dst_sel != `DMDP_DST_NONE);

	dmdp_scratch u_temp (
		.clk     (CLK_SYS),
		.rst     (SYS_RST),
		.wr_en   (temp_wr),                                        // [RL10]
		.wr_adr  (scr_adr),
		.wr_data (result[`DMDP_SCR_W-1:0]),                       // [RL8]
		.rd_adr  (scr_adr),
		.rd_data (temp_rd)
	);

	dmdp_scratch u_firm (
		.clk     (CLK_SYS),
		.rst     (SYS_RST),
		.wr_en   (firm_wr),                                        // [RL10]
		.wr_adr  (scr_adr),
		.wr_data (result[`DMDP_SCR_W-1:0]),                       // [RL8]
		.rd_adr  (scr_adr),
		.rd_data (firm_rd)
	);

	// ************************************************************
	// source decode
	// ************************************************************
	always @* begin
		case (src_sel) // [RL10]
			`DMDP_SEL_TEMP: src_bus = {`DMDP_ZERO_SCRHI, temp_rd}; // [RL8]
			`DMDP_SEL_FIRM: src_bus = {`DMDP_ZERO_SCRHI, firm_rd}; // [RL8]
			`DMDP_SEL_GBUF: src_bus = gbuf_reg;                    // [RL11]
			default:        src_bus = EXT_SRC_DATA;
		endcase
	end

	// ************************************************************
	// rotate and mask
	// ************************************************************
	wire [`DMDP_DATA_W-1:0] src_data = src_bus[`DMDP_DATA_HI:0];
	wire [`DMDP_PAR_W-1:0]  src_par  = src_bus[`DMDP_PAR_HI:`DMDP_PAR_LO];
	reg  [`DMDP_DATA_W-1:0] rot_data;

	always @* begin
		case (rot_sel) // [RL1]
			`DMDP_ROT_8:  rot_data = {src_data[7:0],  src_data[31:8]};
			`DMDP_ROT_16: rot_data = {src_data[15:0], src_data[31:16]};
			`DMDP_ROT_24: rot_data = {src_data[23:0], src_data[31:24]};
			default:      rot_data = src_data;
		endcase
	end

	wire [`DMDP_DATA_W-1:0] msk_data;
	wire [`DMDP_PAR_W-1:0]  gen_par;
	wire [`DMDP_DATA_W-1:0] opb = DST_BUS[`DMDP_DATA_HI:0];
	reg  [`DMDP_DATA_W-1:0] alu_out;

	genvar b;
	generate
		for (b = 0; b < `DMDP_NSLICE; b = b + 1) begin : g_byte
			// unselected bytes are forced to zero
			assign msk_data[b*8 +: 8] = byte_msk[b] ? rot_data[b*8 +: 8] : 8'h00; // [RL2]
			// one parity bit per byte, in byte order
			assign gen_par[b] = (^alu_out[b*8 +: 8]) ^ `DMDP_PAR_ODD;      // [RL12]
		end
	endgenerate

	// ************************************************************
	// find low zero
	// ************************************************************
	reg [5:0] flz_pos;
	integer   k;
	always @* begin
		flz_pos = `DMDP_NO_ZERO; // [RL13]
		for (k = `DMDP_DATA_W - 1; k >= 0; k = k - 1) begin
			if (!src_data[k]) begin
				flz_pos = k[5:0]; // [RL4]
			end
		end
	end

	// ************************************************************
	// arithmetic stage and parity bypass
	// ************************************************************
	always @* begin
		case (alu_op) // [RL3]
			`DMDP_OP_ADD: alu_out = msk_data + opb;
			`DMDP_OP_SUB: alu_out = msk_data - opb;
			`DMDP_OP_AND: alu_out = msk_data & opb;
			`DMDP_OP_OR:  alu_out = msk_data | opb;
			`DMDP_OP_XOR: alu_out = msk_data ^ opb;
			`DMDP_OP_FLZ: alu_out = {26'h000_0000, flz_pos}; // [RL4]
			default:      alu_out = msk_data;
		endcase
	end

	always @* begin
		// parity lanes go around the arithmetic stage unless regenerated
		if (par_gen) begin
			result = {gen_par, alu_out}; // [RL6]
		end else begin
			result = {src_par, alu_out}; // [RL7]
		end
	end

	// ************************************************************
	// gating buffer
	// ************************************************************
	always @* begin
		gbuf_next = gbuf_reg;
		// a load from the gating bus wins over a destination load
		if (gbuf_ld) begin
			gbuf_next = GB_IN;  // [RL11]
		end else if (gbuf_wr) begin
			gbuf_next = result; // [RL11]
		end
	end

	// ************************************************************
	// destination bus register
	// ************************************************************
	// the destination bus also serves as operand b of the next operation
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			DST_BUS   <= `DMDP_ZERO_WORD;
			DST_VALID <= 1'b0;
			DST_SEL   <= `DMDP_DST_NONE;
		end else begin
			DST_VALID <= ld;
			if (ld) begin
				DST_BUS <= result;                        // [RL3]
				DST_SEL <= dst_sel;                       // [RL10]
			end
		end
	end

	// ************************************************************
	// gating bus drive
	// ************************************************************
	// drive enable is cleared in the cycle after a load, so it keeps its previous value during the load itself
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			gbuf_reg <= `DMDP_ZERO_WORD;
			GB_OUT   <= `DMDP_ZERO_WORD;
			GB_OE    <= 1'b0;
		end else begin
			gbuf_reg <= gbuf_next;
			GB_OUT   <= gbuf_next;                        // [RL11]
			if (MI_VALID) begin
				GB_OE <= gb_drive && !gb_load;            // [RL11]
			end
		end
	end

	// ************************************************************
	// matcher
	// ************************************************************
	// the error level holds until the next match operation
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			MATCH_ERR <= 1'b0;
		end else if (match_op) begin
			MATCH_ERR <= (msk_data != opb);               // [RL5]
		end
	end

endmodule // dmdp_top

//--- sim/dmdp_checker.sv
// port assertions for the data manipulation datapath
`include "dmdp_defs.vh"
module dmdp_checker (
	input wire        CLK_SYS,
	input wire        SYS_RST,
	input wire        MI_VALID,
	input wire [63:0] MI_WORD,
	input wire [35:0] EXT_SRC_DATA,
	input wire [35:0] GB_IN,
	input wire [35:0] GB_OUT,
	input wire        GB_OE,
	input wire [35:0] DST_BUS,
	input wire        DST_VALID,
	input wire [3:0]  DST_SEL,
	input wire        MATCH_ERR
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// rotated copy of the external operand for the pass checks
	wire [63:0] rr  = {2{EXT_SRC_DATA[31:0]}} >> {MI_WORD[37:36], 3'b000};
	wire        ld  = MI_VALID && MI_WORD[7:4] != 4'h0;
	wire        ext = ld && MI_WORD[3:0] == 4'h0 && !MI_WORD[21];
	wire        pas = ext && MI_WORD[15:12] == 4'h0;

	result_pulse_a: assert property (ld |=> DST_VALID) else $error("no result pulse");
	idle_hold_a: assert property (!MI_VALID |=> !DST_VALID && $stable(DST_BUS) && $stable(MATCH_ERR))
		else $error("idle cycle changed outputs");
	dest_sel_a: assert property (ext |=> DST_SEL == $past(MI_WORD[7:4])) else $error("wrong select");
	rot_pass_a: assert property (pas && MI_WORD[19:16] == 4'hF |=> DST_BUS[31:0] == $past(rr[31:0]))
		else $error("rotate wrong");
	mask_blank_a: assert property (pas && MI_WORD[19:16] == 4'h0 |=> DST_BUS[31:0] == 32'h0000_0000)
		else $error("mask leak");
	odd_par_a: assert property (ld && MI_WORD[23] |=> ^{DST_BUS[35], DST_BUS[31:24]}
		&& ^{DST_BUS[34], DST_BUS[23:16]} && ^{DST_BUS[33], DST_BUS[15:8]} && ^{DST_BUS[32], DST_BUS[7:0]})
		else $error("parity not odd");
	par_bypass_a: assert property (ext && !MI_WORD[23] |=> DST_BUS[35:32] == $past(EXT_SRC_DATA[35:32]))
		else $error("parity not bypassed");
	no_zero_a: assert property (ext && MI_WORD[15:12] == 4'h6 && &EXT_SRC_DATA[31:0]
		|=> DST_BUS[31:0] == 32'h0000_0020) else $error("no-zero code wrong");
	gb_load_a: assert property (MI_VALID && MI_WORD[21] |=> !GB_OE) else $error("drives while loading");
	gb_drive_a: assert property (MI_VALID && MI_WORD[20] && !MI_WORD[21] |=> GB_OE)
		else $error("gating bus not driven");
	no_dest_a: assert property (MI_VALID && MI_WORD[7:4] == 4'h0 |=> !DST_VALID && $stable(DST_BUS))
		else $error("load without destination");

	cover property (MI_VALID && MI_WORD[15:12] == 4'h6);
	cover property (MI_VALID && MI_WORD[21]);
	cover property ($rose(MATCH_ERR));
endmodule // dmdp_checker

bind dmdp_top dmdp_checker dmdp_checker_inst (.CLK_SYS, .SYS_RST, .MI_VALID, .MI_WORD, .EXT_SRC_DATA, .GB_IN,
	.GB_OUT, .GB_OE, .DST_BUS, .DST_VALID, .DST_SEL, .MATCH_ERR);

//--- sim/dmdp_gbus_model.sv
// far side of the gating bus: resolves the shared wire level
module dmdp_gbus_model (
	input  wire        clk,
	input  wire        oe,
	input  wire [35:0] blk_val,
	input  wire        drv_en,
	input  wire [35:0] drv_val,
	output wire [35:0] bus_lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [35:0] last_reg = 36'h0_0000_0000;
	// an undriven wire shows the inverse of its last driven level
	assign bus_lvl = oe ? blk_val : (drv_en ? drv_val : ~last_reg);
	always @(posedge clk) if (oe || drv_en) last_reg <= bus_lvl;
endmodule // dmdp_gbus_model

//--- sim/tb.sv
// self-checking bench for the data manipulation datapath
`include "dmdp_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [3:0] PG = 4'h8, MT = 4'h4, LD = 4'h2, DR = 4'h1;
	reg         clk = 0, rst = 1, mi_v = 0, pdrv = 0;
	reg  [63:0] mi_w = 64'h0;
	reg  [35:0] ext = 36'h0, pval = 36'h0;
	wire [35:0] gb_in, gb_out, dst_bus;
	wire        gb_oe, dst_v, merr;
	wire [3:0]  dst_sel;
	int         error_cnt = 0, num_checks = 0, k;
	reg  [31:0] a, b;
	reg  [3:0]  m, o;
	reg  [3:0]  es = 4'h0;
	dmdp_top dmdp_top_inst (.CLK_SYS(clk), .SYS_RST(rst), .MI_VALID(mi_v), .MI_WORD(mi_w), .EXT_SRC_DATA(ext),
		.GB_IN(gb_in), .GB_OUT(gb_out), .GB_OE(gb_oe), .DST_BUS(dst_bus), .DST_VALID(dst_v), .DST_SEL(dst_sel),
		.MATCH_ERR(merr));
	dmdp_gbus_model dmdp_gbus_model_inst (.clk(clk), .oe(gb_oe), .blk_val(gb_out), .drv_en(pdrv), .drv_val(pval),
		.bus_lvl(gb_in));
	initial forever #4 clk = ~clk;
	function [3:0] par(input [31:0] d);
		for (int i = 0; i < 4; i++) par[i] = ~^d[8*i+:8];
	endfunction
	function [35:0] pw(input [31:0] d);
		pw = {par(d), d};
	endfunction
	function [63:0] mw(input [3:0] s, d, ad, op, mk, input [1:0] r, input [3:0] c);
		mw = {26'h0, r, 12'h0, c, mk, op, ad, d, s};
	endfunction
	function [31:0] alu(input [3:0] op, input [31:0] x, y);
		case (op)
			`DMDP_OP_ADD: alu = x + y;
			`DMDP_OP_SUB: alu = x - y;
			`DMDP_OP_AND: alu = x & y;
			`DMDP_OP_OR: alu = x | y;
			default: alu = x ^ y;
		endcase
	endfunction
	function [31:0] rm(input [31:0] x, input [1:0] r, input [3:0] mk);
		reg [63:0] t;
		t = {x, x} >> {r, 3'b000};
		for (int i = 0; i < 4; i++) if (!mk[i]) t[8*i+:8] = 8'h00;
		rm = t[31:0];
	endfunction
	task end_of_test;
		if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [35:0] g, e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task mi(input [63:0] w, input [35:0] x);
		@(negedge clk);
		mi_v = 1;
		mi_w = w;
		ext = x;
		if (w[7:4] != 4'h0) es = w[7:4];
		@(negedge clk);
		mi_v = 0;
		chk({31'h0, dst_v, dst_sel}, {31'h0, |w[7:4], es});
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		a = $urandom(7);
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 0;
		chk(dst_bus, 36'h0_0000_0000);
		chk(gb_out, 36'h0_0000_0000);
		chk({29'h0, gb_oe, merr, dst_v, dst_sel}, 36'h0_0000_0000);
		for (k = 0; k < 20; k++) begin
			a = $urandom;
			b = $urandom;
			m = $urandom;
			o = 4'(k % 5 + 1);
			mi(mw(4'h0, 4'h4, 4'h0, 4'h0, 4'hF, 2'h0, PG), pw(a));
			mi(mw(4'h0, 4'h4, 4'h0, o, 4'hF, 2'h0, PG), pw(b));
			chk(dst_bus, pw(alu(o, b, a)));
			mi(mw(4'h0, 4'h4, 4'h0, 4'h0, m, k[1:0], 4'h0), {4'h5, a});
			chk(dst_bus, {4'h5, rm(a, k[1:0], m)});
		end
		for (k = 0; k < 33; k++) begin
			a = ~(32'h1 << k) & ($urandom | ((32'h1 << k) - 32'h1));
			mi(mw(4'h0, 4'h4, 4'h0, 4'h6, 4'hF, 2'h0, PG), pw(a));
			chk(dst_bus, pw(k[31:0]));
		end
		a = $urandom;
		mi(mw(4'h0, 4'h4, 4'h0, 4'h0, 4'hF, 2'h0, PG | MT), pw(a));
		chk({35'h0, merr}, 36'h1);
		mi(mw(4'h0, 4'h4, 4'h0, 4'h0, 4'hF, 2'h0, PG | MT), pw(a));
		chk({35'h0, merr}, 36'h0);
		for (k = 1; k < 3; k++) begin
			a = $urandom;
			b = $urandom;
			m = $urandom;
			mi(mw(4'h0, k[3:0], m, 4'h0, 4'hF, 2'h0, PG), pw(a));
			mi(mw(4'h0, k[3:0], ~m, 4'h0, 4'hF, 2'h0, PG), pw(b));
			mi(mw(k[3:0], 4'h4, m, 4'h0, 4'hF, 2'h0, PG), pw(b));
			chk(dst_bus, pw({16'h0, a[15:0]}));
			mi(mw(k[3:0], 4'h4, ~m, 4'h0, 4'hF, 2'h0, PG), pw(a));
			chk(dst_bus, pw({16'h0, b[15:0]}));
		end
		pval = pw($urandom);
		pdrv = 1;
		mi(mw(4'h0, 4'h4, 4'h0, 4'h0, 4'hF, 2'h0, LD), 36'h0);
		pdrv = 0;
		chk({35'h0, gb_oe}, 36'h0);
		mi(mw(4'h3, 4'h4, 4'h0, 4'h0, 4'hF, 2'h0, DR), 36'h0);
		chk({gb_oe, dst_bus[31:0]}, {1'b1, pval[31:0]});
		chk(gb_out, pval);
		a = $urandom;
		mi(mw(4'h0, 4'h3, 4'h0, 4'h0, 4'hF, 2'h0, PG | DR), pw(a));
		@(negedge clk);
		chk(gb_out, pw(a));
		mi(mw(4'h0, 4'h0, 4'h0, 4'h1, 4'hF, 2'h0, PG), pw($urandom));
		chk(dst_bus, pw(a));
		end_of_test;
	end
	initial begin
		#80000;
		error_cnt++;
		end_of_test;
	end
endmodule // tb
